// file: rtl/uab_pkg.sv
package uab_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_DIVLO = 8'h04;
    localparam logic [7:0] OFF_DIVHI = 8'h08;
    localparam logic [7:0] OFF_RXBUF = 8'h0c;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam logic [7:0] OFF_ISTAT = 8'h14;
    localparam logic [7:0] OFF_ICLR  = 8'h18;
    localparam logic [7:0] OFF_IEN   = 8'h1c;

    // Status register bit positions
    localparam int STAT_FLAG = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_OVF  = 2;

    // Interrupt status / clear / enable bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_OVF  = 2;

    // Reset values
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [7:0] DIV_RST  = 8'h00;
    localparam logic [2:0] IEN_RST  = 3'h0;

    // Sync character timing
    localparam logic [2:0]  AB_RISE_EDGES  = 3'h5;
    localparam logic [15:0] AB_COUNT_START = 16'h0001;

    // Prescaler masks: a tick when all masked bits are ones
    localparam logic [8:0] BASE_MASK_SLOW = 9'h03f;
    localparam logic [8:0] BASE_MASK_MID  = 9'h00f;
    localparam logic [8:0] BASE_MASK_FAST = 9'h003;
    localparam logic [8:0] ABD_MASK_SLOW  = 9'h1ff;
    localparam logic [8:0] ABD_MASK_MID   = 9'h07f;
    localparam logic [8:0] ABD_MASK_FAST  = 9'h01f;

    typedef struct packed {
        logic sync_mode;
        logic wide_divisor_select;
        logic high_speed_select;
        logic wake_on_break_enable;
        logic autobaud_enable;
    } uab_ctrl_s;

    typedef enum logic [1:0] {RATE_SLOW, RATE_MID, RATE_FAST} uab_rate_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAKE_LOW, ST_WAKE_HIGH, ST_START, ST_EDGE1, ST_COUNT
    } uab_state_e;

endpackage

// file: rtl/uab_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module uab_prescale import uab_pkg::*; (
    input  wire logic      pclk,        // System clock
    input  wire logic      presetn,     // Async reset, low
    input  wire uab_rate_e rate,        // Speed/width selection
    output logic           base_tick_q, // Generator base clock enable
    output logic           abd_tick_q   // Autobaud counter clock enable
);

    logic [8:0] cnt_q;
    logic [8:0] bmask;
    logic [8:0] amask;

    // Autobaud mask covers the base mask, so every autobaud tick is a base tick
    always_comb begin
        case (rate)
            RATE_SLOW: begin
                bmask = BASE_MASK_SLOW;
                amask = ABD_MASK_SLOW;
            end
            RATE_MID: begin
                bmask = BASE_MASK_MID;
                amask = ABD_MASK_MID;
            end
            default: begin
                bmask = BASE_MASK_FAST;
                amask = ABD_MASK_FAST;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_tick_q <= 1'b0;
            abd_tick_q  <= 1'b0;
        end else begin
            base_tick_q <= (cnt_q & bmask) == bmask;
            abd_tick_q  <= (cnt_q & amask) == amask;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    tick_nest_a: assert property (
        abd_tick_q |-> base_tick_q)
        else $error("autobaud tick not aligned to base tick");

    fast_base_a: assert property (
        (rate == RATE_FAST) [*6] ##0 base_tick_q
        |-> $past(base_tick_q, 4) && !$past(base_tick_q) && !$past(base_tick_q, 2)
            && !$past(base_tick_q, 3))
        else $error("fast base clock not one in four");

endmodule
`default_nettype wire

// file: rtl/uab_autobaud.sv
`timescale 1ns/100ps
`default_nettype none
module uab_autobaud import uab_pkg::*; (
    input  wire logic        pclk,      // System clock, 125 MHz
    input  wire logic        presetn,   // Async reset, low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB direction
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error on unmapped address
    input  wire logic        rxd,       // Receive line
    output logic             irq,       // Level interrupt
    output logic             rx_hold,   // Receiver state machine held idle
    output logic             baud_tick  // One pulse per bit period
);

    logic        rx_q;
    logic        rise;
    logic        fall;
    uab_ctrl_s   ctrl_q;
    logic [7:0]  div_lo_q;
    logic [7:0]  div_hi_q;
    logic [15:0] div_pair;
    logic [15:0] div_eff;
    uab_state_e  st_q;
    uab_state_e  st_d;
    logic [2:0]  edges_q;
    logic        rflag_q;
    logic [2:0]  istat_q;
    logic [2:0]  ien_q;
    logic [2:0]  iset;
    logic [2:0]  iclr;
    logic [15:0] gen_q;
    uab_rate_e   rate;
    logic        base_tick;
    logic        abd_tick;
    logic        busy;
    logic        done;
    logic        wake_fall;
    logic        wake_end;
    logic        acc;
    logic        wr_en;
    logic        rd_rbuf;
    logic [31:0] rdata;
    logic        hit;

    assign rise     = rxd & ~rx_q;
    assign fall     = ~rxd & rx_q;
    assign div_pair = {div_hi_q, div_lo_q};
    assign busy     = st_q != ST_IDLE;

    // Low-byte modes ignore the high byte; a calibration result above 255 shows there
    assign div_eff = ctrl_q.wide_divisor_select ? div_pair : {8'h00, div_lo_q};

    always_comb begin
        if (ctrl_q.sync_mode) begin
            rate = RATE_FAST;
        end else if (ctrl_q.wide_divisor_select && ctrl_q.high_speed_select) begin
            rate = RATE_FAST;
        end else if (ctrl_q.wide_divisor_select || ctrl_q.high_speed_select) begin
            rate = RATE_MID;
        end else begin
            rate = RATE_SLOW;
        end
    end

    uab_prescale u_prescale (
        .pclk        (pclk),
        .presetn     (presetn),
        .rate        (rate),
        .base_tick_q (base_tick),
        .abd_tick_q  (abd_tick)
    );

    // APB access phase completes when pready is high
    assign acc     = psel & penable & pready;
    assign wr_en   = acc & pwrite;
    assign rd_rbuf = acc & ~pwrite & (paddr == OFF_RXBUF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= 1'b1;
        end else begin
            rx_q <= rxd;
        end
    end

    // Calibration sequencer
    assign wake_fall = (st_q == ST_WAKE_LOW) && fall;
    assign wake_end  = (st_q == ST_WAKE_HIGH) && rise;
    assign done = (st_q == ST_COUNT) && rise
               && (edges_q == 3'(AB_RISE_EDGES - 3'h1));

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (ctrl_q.wake_on_break_enable) begin
                    st_d = ST_WAKE_LOW;
                end else if (ctrl_q.autobaud_enable) begin
                    st_d = ST_START;
                end
            end
            ST_WAKE_LOW: begin
                if (!ctrl_q.wake_on_break_enable) begin
                    st_d = ST_IDLE;
                end else if (fall) begin
                    st_d = ST_WAKE_HIGH;
                end
            end
            ST_WAKE_HIGH: begin
                if (rise) begin
                    st_d = ctrl_q.autobaud_enable ? ST_START : ST_IDLE;
                end
            end
            ST_START: begin
                if (!ctrl_q.autobaud_enable) begin
                    st_d = ST_IDLE;
                end else if (fall) begin
                    st_d = ST_EDGE1;
                end
            end
            ST_EDGE1: begin
                if (!ctrl_q.autobaud_enable) begin
                    st_d = ST_IDLE;
                end else if (rise) begin
                    st_d = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!ctrl_q.autobaud_enable || done) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold <= 1'b0;
        end else begin
            rx_hold <= st_d != ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_q <= 3'h0;
        end else if (st_q == ST_EDGE1 && rise) begin
            edges_q <= 3'h1;
        end else if (st_q == ST_COUNT && rise) begin
            edges_q <= edges_q + 3'h1;
        end
    end

    // Hardware clears win over a same-cycle software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (wr_en && paddr == OFF_CTRL) begin
                ctrl_q <= pwdata[4:0];
            end
            if (wake_end) begin
                ctrl_q.wake_on_break_enable <= 1'b0;
            end
            if (done) begin
                ctrl_q.autobaud_enable <= 1'b0;
            end
        end
    end

    // Software writes are dropped whenever the sequencer is busy, including while the pair is the measuring counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_lo_q <= DIV_RST;
            div_hi_q <= DIV_RST;
        end else if (st_q == ST_EDGE1 && rise && ctrl_q.autobaud_enable) begin
            {div_hi_q, div_lo_q} <= AB_COUNT_START;
        end else if (st_q == ST_COUNT) begin
            if (abd_tick && !rise) begin
                {div_hi_q, div_lo_q} <= div_pair + 16'h0001;
            end
        end else if (wr_en && !busy) begin
            if (paddr == OFF_DIVLO) begin
                div_lo_q <= pwdata[7:0];
            end
            if (paddr == OFF_DIVHI) begin
                div_hi_q <= pwdata[7:0];
            end
        end
    end

    // Set wins over the buffer read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rflag_q <= 1'b0;
        end else if (done || wake_fall) begin
            rflag_q <= 1'b1;
        end else if (rd_rbuf) begin
            rflag_q <= 1'b0;
        end
    end

    // Interrupt status, sticky with write-one-to-clear
    always_comb begin
        iset           = 3'h0;
        iset[IRQ_DONE] = done;
        iset[IRQ_WAKE] = wake_fall;
        iset[IRQ_OVF]  = done && (div_hi_q != 8'h00);
        iclr = (wr_en && paddr == OFF_ICLR) ? pwdata[2:0] : 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 3'h0;
        end else begin
            istat_q <= (istat_q & ~iclr) | iset;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q <= IEN_RST;
        end else if (wr_en && paddr == OFF_IEN) begin
            ien_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_q & ien_q);
        end
    end

    // Bit timer; gated on the next state so no tick slips out as calibration starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q     <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (st_d != ST_IDLE) begin
            gen_q     <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (base_tick) begin
            if (gen_q == 16'h0000) begin
                gen_q     <= div_eff;
                baud_tick <= 1'b1;
            end else begin
                gen_q     <= gen_q - 16'h0001;
                baud_tick <= 1'b0;
            end
        end else begin
            baud_tick <= 1'b0;
        end
    end

    // Register read mux; receive datapath is absent so the buffer reads zero
    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (paddr)
            OFF_CTRL:  rdata[4:0] = ctrl_q;
            OFF_DIVLO: rdata[7:0] = div_lo_q;
            OFF_DIVHI: rdata[7:0] = div_hi_q;
            OFF_RXBUF: rdata      = 32'h0000_0000;
            OFF_STAT: begin
                rdata[STAT_FLAG] = rflag_q;
                rdata[STAT_BUSY] = busy;
                rdata[STAT_OVF]  = div_hi_q != 8'h00;
            end
            OFF_ISTAT: rdata[2:0] = istat_q;
            OFF_ICLR:  rdata      = 32'h0000_0000;
            OFF_IEN:   rdata[2:0] = ien_q;
            default:   hit        = 1'b0;
        endcase
    end

    // One wait-free access phase; read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel && !penable) begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= ~hit;
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    hold_idle_a: assert property (
        busy |-> rx_hold && !baud_tick)
        else $error("receiver not held during calibration");

    count_start_a: assert property (
        st_q == ST_EDGE1 && rise && ctrl_q.autobaud_enable
        |=> div_pair == AB_COUNT_START && st_q == ST_COUNT)
        else $error("counter did not start at one");

    count_step_a: assert property (
        st_q == ST_COUNT && abd_tick && !rise
        |=> div_pair == $past(div_pair) + 16'h0001)
        else $error("counter did not advance on autobaud tick");

    count_hold_a: assert property (
        st_q == ST_COUNT && !abd_tick |=> $stable(div_pair))
        else $error("counter moved without autobaud tick");

    fifth_edge_a: assert property (
        done |=> !ctrl_q.autobaud_enable && rflag_q && st_q == ST_IDLE
                 && $stable(div_pair))
        else $error("completion did not clear enable or set flag");

    flag_keep_a: assert property (
        rflag_q && !rd_rbuf |=> rflag_q)
        else $error("flag cleared without buffer read");

    flag_clear_a: assert property (
        rflag_q && rd_rbuf && !done && !wake_fall |=> !rflag_q)
        else $error("buffer read did not clear flag");

    wake_skip_a: assert property (
        wake_end && ctrl_q.autobaud_enable
        |=> st_q == ST_START && !ctrl_q.wake_on_break_enable)
        else $error("break end did not arm measurement");

    ovf_view_a: assert property (
        done && !istat_q[IRQ_OVF] |=> istat_q[IRQ_OVF] == (div_hi_q != 8'h00))
        else $error("overflow status wrong after calibration");

    bit_period_a: assert property (
        baud_tick && $past(div_eff) == 16'h0000
        ##1 (rate == RATE_FAST && div_eff == 16'h0000 && !rx_hold) [*4]
        |-> baud_tick && !$past(baud_tick) && !$past(baud_tick, 2) && !$past(baud_tick, 3))
        else $error("fast bit period not four clocks");

endmodule
`default_nettype wire

// file: tb/uab_sync_tx.sv
`timescale 1ns/100ps
`default_nettype none
module uab_sync_tx (
    input  wire logic pclk, // System clock
    output logic      rxd   // Serial line, idles high
);
    initial rxd = 1'b1;

    task automatic bit_out(input logic v, input int cyc);
        rxd <= v;
        repeat (cyc) @(posedge pclk);
    endtask

    // Call just after a rising edge; the line returns high between frames
    task automatic send(input logic [7:0] d, input int cyc, input logic brk);
        if (brk) begin
            bit_out(1'b0, 12 * cyc);
            bit_out(1'b1, 2 * cyc);
        end
        bit_out(1'b0, cyc);
        for (int i = 0; i < 8; i++) begin
            bit_out(d[i], cyc);
        end
        bit_out(1'b1, cyc);
    endtask
endmodule
`default_nettype wire

// file: tb/test_uab_autobaud.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_uab_autobaud;
    import uab_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        irq;
    logic        rx_hold;
    logic        baud_tick;
    logic [31:0] r;
    logic        e;
    int          failures;
    int          compares;
    int          g;

    uab_autobaud dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .irq(irq), .rx_hold(rx_hold), .baud_tick(baud_tick));
    uab_sync_tx tx_u (.pclk(pclk), .rxd(rxd));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            give_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        x;
        apb(1'b1, a, d, q, x);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Count is about eight bit periods over the counter clock, plus the start value
    task automatic calib(input logic [4:0] c, input int cyc, input logic brk,
                         input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] v;
        wr(OFF_CTRL, {27'h0, c});
        repeat (2) @(posedge pclk);
        `CHK(rx_hold, 1'b1)
        tx_u.send(8'h55, cyc, brk);
        repeat (4) @(posedge pclk);
        `CHK(rx_hold, 1'b0)
        rd(OFF_CTRL);
        `CHK(r[1:0], 2'b00)
        rd(OFF_STAT);
        `CHK(r[STAT_FLAG], 1'b1)
        `CHK(r[STAT_OVF], (lo > 16'h00ff))
        rd(OFF_DIVLO);
        v[7:0] = r[7:0];
        rd(OFF_DIVHI);
        v[15:8] = r[7:0];
        `CHK((v >= lo && v <= hi), 1'b1)
        rd(OFF_STAT);
        `CHK(r[STAT_FLAG], 1'b1)
        rd(OFF_RXBUF);
        rd(OFF_STAT);
        `CHK(r[STAT_FLAG], 1'b0)
    endtask

    task automatic tick_gap(input logic [4:0] c, input logic [7:0] dv);
        int n;
        wr(OFF_CTRL, {27'h0, c});
        wr(OFF_DIVLO, {24'h0, dv});
        wr(OFF_DIVHI, 32'h0);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (baud_tick !== 1'b1 && n < 2000);
            if (n >= 2000) begin
                failures++;
                give_verdict();
            end
        end
        g = n;
    endtask

    initial begin
        failures = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL);
        `CHK(r, 32'h0)
        rd(OFF_DIVLO);
        `CHK(r, 32'h0)
        rd(OFF_IEN);
        `CHK(r, 32'h0)
        rd(8'h20);
        `CHK({e, r}, {1'b1, 32'h0})
        // Slow, two middle settings, fast, fast after break; bit period equals the counter clock except in the sync run at 1200
        calib(5'h01, 512, 1'b0, 16'd8, 16'd10);
        calib(5'h05, 128, 1'b0, 16'd8, 16'd10);
        calib(5'h09, 128, 1'b0, 16'd8, 16'd10);
        calib(5'h0d, 32, 1'b0, 16'd8, 16'd10);
        calib(5'h0f, 32, 1'b1, 16'd8, 16'd10);
        calib(5'h15, 1200, 1'b0, 16'd300, 16'd302);
        `CHK(irq, 1'b0)
        rd(OFF_ISTAT);
        `CHK(r[IRQ_DONE], 1'b1)
        wr(OFF_IEN, 32'h1);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(OFF_ICLR, 32'h7);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        rd(OFF_ISTAT);
        `CHK(r, 32'h0)
        tick_gap(5'h0c, 8'h03);
        `CHK(g, 16)
        tick_gap(5'h04, 8'h01);
        `CHK(g, 32)
        tick_gap(5'h00, 8'h00);
        `CHK(g, 64)
        tick_gap(5'h0c, 8'h00);
        `CHK(g, 4)
        give_verdict();
    end
endmodule
`default_nettype wire
